// ==== rtl/dmcp_pkg.sv ====
/*
 * Constants shared by both ends of the pin mapping and continuous data link.
 * Assumes a single 100 MHz pclk domain on each side.
 */
package dmcp_pkg;
	localparam int          PIN_CNT        = 6;
	localparam int          CODE_W         = 2;
	localparam logic [1:0]  CODE_00        = 2'h0;
	localparam logic [1:0]  CODE_01        = 2'h1;
	localparam logic [1:0]  CODE_10        = 2'h2;
	localparam logic [1:0]  CODE_11        = 2'h3;
	// Operating states, one-hot
	typedef enum logic [4:0] {
		DMCP_SLEEP = 5'h01,
		DMCP_STDBY = 5'h02,
		DMCP_FS    = 5'h04,
		DMCP_RX    = 5'h08,
		DMCP_TX    = 5'h10
	} dmcp_opmode_t;
	localparam logic [2:0]  OPM_SLEEP      = 3'h0;
	localparam logic [2:0]  OPM_STDBY      = 3'h1;
	localparam logic [2:0]  OPM_FS         = 3'h2;
	localparam logic [2:0]  OPM_RX         = 3'h3;
	localparam logic [2:0]  OPM_TX         = 3'h4;
	// Bit period in pclk cycles (device-generated bit clock)
	localparam logic [7:0]  BIT_DIV        = 8'h0a;
	localparam logic [7:0]  BIT_HALF       = 8'h05;
	// Host APB map
	localparam logic [11:0] ADDR_CTRL      = 12'h000;
	localparam logic [11:0] ADDR_TXDATA    = 12'h004;
	localparam logic [11:0] ADDR_RXDATA    = 12'h008;
	localparam logic [11:0] ADDR_STAT      = 12'h00c;
	localparam logic [11:0] ADDR_MASK      = 12'h010;
	localparam logic [11:0] ADDR_PINS      = 12'h014;
	localparam int          ST_RXBIT       = 0;
	localparam int          ST_TXTAKEN     = 1;
	localparam int          ST_PIN0        = 2;
	localparam int          ST_W           = 3;
	localparam int          CTRL_TXEN      = 0;
endpackage : dmcp_pkg

// ==== rtl/dmcp_if.sv ====
/*
 * Pin-level carrier between the radio pin mux and the microcontroller end.
 * Resolves the two-way data pin here from the enables; the host enable wins over the device pin 2 enable.
 */
`timescale 1ns/1ps
interface dmcp_if;
	logic [5:0] dio_o;
	logic [5:0] dio_oe;
	logic       data_host_o;
	logic       data_host_oe;
	logic       data_line;
	assign data_line = data_host_oe ? data_host_o : (dio_oe[2] ? dio_o[2] : 1'b0);
	modport dev  (output dio_o, output dio_oe, input data_line);
	modport host (input dio_o, output data_host_o, output data_host_oe, input data_line);
endinterface : dmcp_if

// ==== rtl/dmcp_sync2.sv ====
/*
 * Two-flop synchroniser for inputs from outside the pclk domain.
 * Assumes the first flop feeds only the second.
 */
`timescale 1ns/1ps
module dmcp_sync2 (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic d,
	output logic      q
);
	logic meta_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : dmcp_sync2

// ==== rtl/dmcp_device.sv ====
/*
 * Radio-side digital pin mux and continuous-mode bit clock / data path.
 * Assumes status inputs are pclk-synchronous; the data pin from the host is synchronised here.
 */
`timescale 1ns/1ps
// Behaviour
// - Six pins routed by two config registers
// - Route depends on code and operating state
// - Packet mode pin 0/1 signal selection
// - Continuous mode pin 0/1/3/4/5 selection; pin 2 fixed as data
// - Continuous mode bypasses FIFO, raw data
// - Transmit drives bit clock on pin 1
// - Data sampled on bit clock rising edge
// - Host paces shaped data by clock
// - Rx without sync: raw data, no clock
// - Rx with sync: cleaned data, clock
// - Rx data changes on falling edge
// - Software should enable bit synchronizer
// - Packet mode forces bit synchronizer on
// - Payload-ready on pin 0 in rx
// - Packet-sent high after last bit
module dmcp_device
	import dmcp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	dmcp_if.dev              pins,
	input  wire logic [7:0]  pin_route_cfg_a,
	input  wire logic [7:0]  pin_route_cfg_b,
	input  wire logic        packet_mode,
	input  wire logic [2:0]  op_mode,
	input  wire logic        bit_sync_en,
	input  wire logic        demod_raw,
	output logic             mod_data,
	output logic             mod_data_valid,
	input  wire logic        payload_ready_a,
	input  wire logic        packet_sent_b,
	input  wire logic        crc_ok_c,
	input  wire logic        fifo_level_hit,
	input  wire logic        fifo_empty_d,
	input  wire logic        fifo_full_e,
	input  wire logic        sync_address_f,
	input  wire logic        rx_ready_g,
	input  wire logic        tx_ready_h,
	input  wire logic        preamble_detect_i,
	input  wire logic        temp_change_j,
	input  wire logic        low_battery,
	input  wire logic        pll_lock,
	input  wire logic        mode_ready_k,
	input  wire logic        ref_clock_out,
	input  wire logic        timeout_evt,
	output logic             bit_sync_active
);
	dmcp_opmode_t st;
	logic [1:0]   code [PIN_CNT];
	logic [5:0]   sel;
	logic [7:0]   div_r;
	logic         bclk_r;
	logic         rxdat_r;
	logic         data_in_s;
	logic         tx_c;
	logic         rx_c;
	logic         tmp_bat;

	always_comb begin
		unique case (op_mode)
			OPM_STDBY: st = DMCP_STDBY;
			OPM_FS:    st = DMCP_FS;
			OPM_RX:    st = DMCP_RX;
			OPM_TX:    st = DMCP_TX;
			default:   st = DMCP_SLEEP;
		endcase
	end

	// Codes: cfg_a holds pins 0..3, cfg_b pins 4..5, two bits each
	assign code[0] = pin_route_cfg_a[7:6];
	assign code[1] = pin_route_cfg_a[5:4];
	assign code[2] = pin_route_cfg_a[3:2];
	assign code[3] = pin_route_cfg_a[1:0];
	assign code[4] = pin_route_cfg_b[7:6];
	assign code[5] = pin_route_cfg_b[5:4];

	assign bit_sync_active = bit_sync_en | packet_mode;
	assign tx_c    = !packet_mode && st == DMCP_TX;
	assign rx_c    = !packet_mode && st == DMCP_RX;
	assign tmp_bat = temp_change_j | low_battery;

	// Bit clock divider; one bit period per BIT_DIV cycles
	// Idles at the wrap count so the first high phase is full length
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r  <= BIT_DIV - 8'h01;
			bclk_r <= 1'b0;
		end else if (tx_c || (rx_c && bit_sync_active)) begin
			div_r  <= (div_r == BIT_DIV - 8'h01) ? 8'h00 : div_r + 8'h01;
			bclk_r <= (div_r < BIT_HALF - 8'h01) || (div_r == BIT_DIV - 8'h01);
		end else begin
			div_r  <= BIT_DIV - 8'h01;
			bclk_r <= 1'b0;
		end
	end

	dmcp_sync2 u_data_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pins.data_line),
		.q       (data_in_s)
	);

	// Tx: take data at the bit clock rising edge; host data goes straight to modulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_data       <= 1'b0;
			mod_data_valid <= 1'b0;
		end else begin
			mod_data_valid <= tx_c && div_r == BIT_DIV - 8'h01;
			if (tx_c && div_r == BIT_DIV - 8'h01)
				mod_data <= data_in_s;
		end
	end

	// Rx retimed data changes at the falling edge of the bit clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rxdat_r <= 1'b0;
		else if (rx_c && bit_sync_active && div_r == BIT_HALF - 8'h01)
			rxdat_r <= demod_raw;
	end

	// Per-pin routing
	always_comb begin
		sel = 6'h00;
		if (packet_mode) begin
			unique case (code[0])
				CODE_00: sel[0] = (st == DMCP_RX) ? payload_ready_a : (st == DMCP_TX) ? packet_sent_b : 1'b0;
				CODE_01: sel[0] = (st == DMCP_RX) ? crc_ok_c : 1'b0;
				CODE_10: sel[0] = 1'b0;
				CODE_11: sel[0] = (st != DMCP_SLEEP) ? tmp_bat : 1'b0;
			endcase
			unique case (code[1])
				CODE_00: sel[1] = fifo_level_hit;
				CODE_01: sel[1] = fifo_empty_d;
				CODE_10: sel[1] = fifo_full_e;
				CODE_11: sel[1] = 1'b0;
			endcase
			unique case (code[2])
				CODE_01: sel[2] = (st == DMCP_RX) ? rx_ready_g : 1'b0;
				CODE_10: sel[2] = (st == DMCP_RX) ? timeout_evt : fifo_full_e;
				CODE_11: sel[2] = (st == DMCP_RX) ? sync_address_f : fifo_full_e;
				default: sel[2] = fifo_full_e;
			endcase
			unique case (code[3])
				CODE_01: sel[3] = (st == DMCP_TX) ? tx_ready_h : 1'b0;
				default: sel[3] = fifo_empty_d;
			endcase
			unique case (code[4])
				CODE_00: sel[4] = (st != DMCP_SLEEP) ? tmp_bat : 1'b0;
				CODE_01: sel[4] = (st == DMCP_RX || st == DMCP_TX || st == DMCP_FS) ? pll_lock : 1'b0;
				CODE_10: sel[4] = (st == DMCP_RX) ? timeout_evt : 1'b0;
				CODE_11: sel[4] = (st == DMCP_RX) ? preamble_detect_i : 1'b0;
			endcase
		end else begin
			unique case (code[0])
				CODE_00: sel[0] = (st == DMCP_RX) ? sync_address_f : (st == DMCP_TX) ? tx_ready_h : 1'b0;
				CODE_01: sel[0] = (st == DMCP_RX) ? preamble_detect_i : 1'b0;
				CODE_10: sel[0] = (st == DMCP_RX) ? rx_ready_g : (st == DMCP_TX) ? tx_ready_h : 1'b0;
				CODE_11: sel[0] = 1'b0;
			endcase
			unique case (code[1])
				CODE_00: sel[1] = bclk_r;
				CODE_01: sel[1] = (st == DMCP_RX) ? preamble_detect_i : 1'b0;
				default: sel[1] = 1'b0;
			endcase
			sel[2] = (st == DMCP_RX) ? (bit_sync_active ? rxdat_r : demod_raw) : 1'b0;
			unique case (code[3])
				CODE_00: sel[3] = (st == DMCP_RX) ? timeout_evt : 1'b0;
				CODE_01: sel[3] = (st == DMCP_RX) ? preamble_detect_i : 1'b0;
				CODE_10: sel[3] = 1'b0;
				CODE_11: sel[3] = (st != DMCP_SLEEP) ? tmp_bat : 1'b0;
			endcase
			unique case (code[4])
				CODE_00: sel[4] = (st != DMCP_SLEEP) ? tmp_bat : 1'b0;
				CODE_01: sel[4] = (st == DMCP_RX || st == DMCP_TX || st == DMCP_FS) ? pll_lock : 1'b0;
				CODE_10: sel[4] = (st == DMCP_RX) ? timeout_evt : 1'b0;
				CODE_11: sel[4] = (st != DMCP_SLEEP) ? mode_ready_k : 1'b0;
			endcase
		end
		unique case (code[5])
			CODE_00: sel[5] = ref_clock_out;
			CODE_01: sel[5] = (st == DMCP_RX || st == DMCP_TX || st == DMCP_FS) ? pll_lock : 1'b0;
			CODE_10: sel[5] = packet_mode ? 1'b0 : (st == DMCP_RX) ? preamble_detect_i : 1'b0;
			CODE_11: sel[5] = (st != DMCP_SLEEP) ? mode_ready_k : 1'b0;
		endcase
	end

	// Pins are registered; data pin released in continuous transmit so the host can drive it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins.dio_o  <= 6'h00;
			pins.dio_oe <= 6'h00;
		end else begin
			pins.dio_o  <= sel;
			pins.dio_oe <= tx_c ? 6'h3b : 6'h3f;
		end
	end
endmodule : dmcp_device

// ==== rtl/dmcp_host.sv ====
/*
 * Microcontroller end: APB registers, continuous-mode tx/rx bit shifting, interrupt.
 * Assumes pins come from another domain and are synchronised before use.
 */
`timescale 1ns/1ps
module dmcp_host
	import dmcp_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	dmcp_if.host             pins,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq
);
	logic              clk_s;
	logic              dat_s;
	logic              pin0_s;
	logic              clk_d_r;
	logic              pin0_d_r;
	logic              txen_r;
	logic              txbit_r;
	logic              rxbit_r;
	logic [ST_W-1:0]   stat_r;
	logic [ST_W-1:0]   mask_r;
	logic [ST_W-1:0]   ev;
	logic              wr;
	logic              rise;
	logic              fall;
	logic [5:0]        pin_s;
	logic [31:0]       rdata_nxt;

	// Every pin crosses from the radio side, so all six are synchronised
	for (genvar gi = 0; gi < PIN_CNT; gi++) begin : g_pin_sync
		dmcp_sync2 u_pin_sync (
			.pclk    (pclk),
			.presetn (presetn),
			.d       (pins.dio_o[gi]),
			.q       (pin_s[gi])
		);
	end
	dmcp_sync2 u_dat_sync (.pclk(pclk), .presetn(presetn), .d(pins.data_line), .q(dat_s));
	assign clk_s  = pin_s[1];
	assign pin0_s = pin_s[0];

	assign rise    = clk_s & ~clk_d_r;
	assign fall    = ~clk_s & clk_d_r;
	assign wr      = psel & penable & pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_d_r  <= 1'b0;
			pin0_d_r <= 1'b0;
		end else begin
			clk_d_r  <= clk_s;
			pin0_d_r <= pin0_s;
		end
	end

	// Receive on rising edge; data stable since falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rxbit_r <= 1'b0;
		else if (rise && !txen_r)
			rxbit_r <= dat_s;
	end

	// Change tx data just after the falling edge, away from the sampling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins.data_host_o  <= 1'b0;
			pins.data_host_oe <= 1'b0;
		end else begin
			pins.data_host_oe <= txen_r;
			if (fall)
				pins.data_host_o <= txbit_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txen_r  <= 1'b0;
			txbit_r <= 1'b0;
			mask_r  <= '0;
		end else if (wr) begin
			if (paddr == ADDR_CTRL)
				txen_r <= pwdata[CTRL_TXEN];
			if (paddr == ADDR_TXDATA)
				txbit_r <= pwdata[0];
			if (paddr == ADDR_MASK)
				mask_r <= pwdata[ST_W-1:0];
		end
	end

	assign ev[ST_RXBIT]   = rise & ~txen_r;
	assign ev[ST_TXTAKEN] = rise & txen_r;
	assign ev[ST_PIN0]    = pin0_s & ~pin0_d_r;

	// Set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stat_r <= '0;
		else
			stat_r <= (stat_r & ~((wr && paddr == ADDR_STAT) ? pwdata[ST_W-1:0] : '0)) | ev;
	end

	assign irq = |(stat_r & mask_r);

	always_comb begin
		unique case (paddr)
			ADDR_CTRL:   rdata_nxt = {31'h0, txen_r};
			ADDR_TXDATA: rdata_nxt = {31'h0, txbit_r};
			ADDR_RXDATA: rdata_nxt = {31'h0, rxbit_r};
			ADDR_STAT:   rdata_nxt = {29'h0, stat_r};
			ADDR_MASK:   rdata_nxt = {29'h0, mask_r};
			ADDR_PINS:   rdata_nxt = {26'h0, pin_s};
			default:     rdata_nxt = 32'h0;
		endcase
	end

	// Captured in the setup cycle so it stands through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable)
			prdata <= rdata_nxt;
	end
endmodule : dmcp_host

// ==== testbench/dmcp_properties.sv ====
/* Checker on the pin bus between device and host ends.
   Assumes tb_top feeds it the interface signals and device config. */
`timescale 1ns/1ps
module dmcp_properties
	import dmcp_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [5:0] dio_o,
	input wire logic [5:0] dio_oe,
	input wire logic       data_host_o,
	input wire logic       data_host_oe,
	input wire logic [7:0] pin_route_cfg_a,
	input wire logic       packet_mode,
	input wire logic [2:0] op_mode,
	input wire logic       bit_sync_en,
	input wire logic       payload_ready_a,
	input wire logic       tx_ready_h
);
	logic [12:0] cfg;
	logic [12:0] cfg_r;
	logic [12:0] cfg_r2;
	logic        steady;
	logic        run;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign cfg    = {pin_route_cfg_a, packet_mode, op_mode, bit_sync_en};
	// Bit clock passes two flops to the pin, so wait two cycles after config settles
	assign steady = cfg == cfg_r && cfg_r == cfg_r2;
	assign run    = !packet_mode && pin_route_cfg_a[5:4] == CODE_00
		&& (op_mode == OPM_TX || (op_mode == OPM_RX && bit_sync_en));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r  <= 13'h1fff;
			cfg_r2 <= 13'h1fff;
		end else begin
			cfg_r  <= cfg;
			cfg_r2 <= cfg_r;
		end
	end
	chk_clk_shape: assert property ($rose(dio_o[1]) && run |-> (dio_o[1] || !run)[*5] ##1 !dio_o[1])
		else $error("bit clock high phase wrong");
	chk_clk_quiet: assert property (steady && !packet_mode && pin_route_cfg_a[5:4] == CODE_00
		&& (op_mode == OPM_SLEEP || (op_mode == OPM_RX && !bit_sync_en)) |-> !dio_o[1])
		else $error("bit clock without sync");
	chk_rx_fall: assert property (steady && run && op_mode == OPM_RX && $changed(dio_o[2]) |-> !dio_o[1])
		else $error("rx data moved while clock high");
	chk_host_change: assert property (data_host_oe && $past(data_host_oe) && $changed(data_host_o)
		|-> !dio_o[1])
		else $error("host data moved near rising edge");
	chk_data_release: assert property (steady && !packet_mode && op_mode == OPM_TX |-> !dio_oe[2])
		else $error("device drives data pin in tx");
	chk_pkt_ready: assert property (steady && packet_mode && op_mode == OPM_RX
		&& pin_route_cfg_a[7:6] == CODE_00 |-> dio_o[0] == $past(payload_ready_a))
		else $error("payload ready not on pin 0");
	chk_tx_ready: assert property (steady && !packet_mode && op_mode == OPM_TX
		&& pin_route_cfg_a[7:6] == CODE_00 |-> dio_o[0] == $past(tx_ready_h))
		else $error("tx ready not on pin 0");
	chk_sleep_quiet: assert property (steady && !packet_mode && op_mode == OPM_SLEEP |-> dio_o[4:0] == 5'h00)
		else $error("pin driven high in sleep");
	cover property (run && op_mode == OPM_TX && $rose(dio_o[1]));
	cover property (run && op_mode == OPM_RX && $changed(dio_o[2]));
	cover property (packet_mode && dio_o[0]);
endmodule : dmcp_properties

// ==== testbench/tb_top.sv ====
/* Bench: device and host ends joined by the pin interface, host on APB.
   Assumes the package, interface and both ends are compiled first. */
`timescale 1ns/1ps
module tb_top
	import dmcp_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic        pkt, bse, raw, mod_data, mod_valid, bsa;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [7:0]  cfg_a, cfg_b;
	logic [2:0]  opm;
	logic [15:0] st;
	int          num_errors, n_checks, n;
	dmcp_if pins();
	dmcp_device i_dmcp_device (.pclk(pclk), .presetn(presetn), .pins(pins.dev), .pin_route_cfg_a(cfg_a),
		.pin_route_cfg_b(cfg_b), .packet_mode(pkt), .op_mode(opm), .bit_sync_en(bse), .demod_raw(raw),
		.mod_data(mod_data), .mod_data_valid(mod_valid), .payload_ready_a(st[0]), .packet_sent_b(st[1]),
		.crc_ok_c(st[2]), .fifo_level_hit(st[3]), .fifo_empty_d(st[4]), .fifo_full_e(st[5]),
		.sync_address_f(st[6]), .rx_ready_g(st[7]), .tx_ready_h(st[8]), .preamble_detect_i(st[9]),
		.temp_change_j(st[10]), .low_battery(st[11]), .pll_lock(st[12]), .mode_ready_k(st[13]),
		.ref_clock_out(st[14]), .timeout_evt(st[15]), .bit_sync_active(bsa));
	dmcp_host i_dmcp_host (.pclk(pclk), .presetn(presetn), .pins(pins.host), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq));
	dmcp_properties i_props (.pclk(pclk), .presetn(presetn), .dio_o(pins.dio_o), .dio_oe(pins.dio_oe),
		.data_host_o(pins.data_host_o), .data_host_oe(pins.data_host_oe), .pin_route_cfg_a(cfg_a),
		.packet_mode(pkt), .op_mode(opm), .bit_sync_en(bse), .payload_ready_a(st[0]), .tx_ready_h(st[8]));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up
	// Starts on a fresh edge so back-to-back calls never double-drive psel
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_valid();
		do @(posedge pclk); while (mod_valid !== 1'b1);
	endtask : wait_valid
	task automatic count_rises();
		logic prev;
		prev = pins.dio_o[1];
		n = 0;
		repeat (40) begin
			@(posedge pclk);
			if (pins.dio_o[1] === 1'b1 && prev === 1'b0) n++;
			prev = pins.dio_o[1];
		end
	endtask : count_rises
	task automatic t_route(input logic p, input logic [2:0] m, input logic [7:0] a, input logic [7:0] b,
		input int idx, input int pin, input logic exp);
		@(posedge pclk);
		pkt   <= p;
		opm   <= m;
		cfg_a <= a;
		cfg_b <= b;
		st    <= 16'h0000;
		repeat (3) @(posedge pclk);
		chk({31'h0, pins.dio_o[pin]}, 32'h0);
		st[idx] <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, pins.dio_o[pin]}, {31'h0, exp});
		apb(1'b0, ADDR_PINS, 32'h0);
		chk({31'h0, rd[pin]}, {31'h0, exp});
	endtask : t_route
	task automatic t_regs();
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, ADDR_MASK, 32'h5);
		apb(1'b1, 12'h0f0, 32'hffffffff);
		apb(1'b0, ADDR_MASK, 32'h0);
		chk(rd, 32'h5);
		apb(1'b0, 12'h0f0, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, pslverr}, 32'h0);
		apb(1'b1, ADDR_MASK, 32'h0);
	endtask : t_regs
	task automatic t_cont_tx();
		logic [2:0] pat;
		pat = 3'b101;
		t_route(1'b0, OPM_TX, 8'h00, 8'h00, 8, 0, 1'b1);
		apb(1'b1, ADDR_CTRL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			wait_valid();
			apb(1'b1, ADDR_TXDATA, {31'h0, pat[i]});
			wait_valid();
			wait_valid();
			chk({31'h0, mod_data}, {31'h0, pat[i]});
		end
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rd & 32'h2, 32'h2);
		chk(rd & 32'h4, 32'h4);
		apb(1'b1, ADDR_MASK, 32'h2);
		apb(1'b1, ADDR_CTRL, 32'h0);
		chk({31'h0, irq}, 32'h1);
		opm <= OPM_STDBY;
		repeat (12) @(posedge pclk);
		apb(1'b1, ADDR_STAT, 32'h7);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask : t_cont_tx
	task automatic t_cont_rx();
		@(posedge pclk);
		opm <= OPM_RX;
		bse <= 1'b1;
		raw <= 1'b1;
		repeat (30) @(posedge pclk);
		count_rises();
		chk(32'(n), 32'h4);
		chk({31'h0, pins.dio_o[2]}, 32'h1);
		apb(1'b0, ADDR_RXDATA, 32'h0);
		chk(rd, 32'h1);
		bse <= 1'b0;
		raw <= 1'b0;
		repeat (5) @(posedge pclk);
		count_rises();
		chk(32'(n), 32'h0);
		chk({31'h0, pins.dio_o[2]}, 32'h0);
		pkt <= 1'b1;
		@(posedge pclk);
		chk({31'h0, bsa}, 32'h1);
	endtask : t_cont_rx
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Whole run is near 520 cycles; 5000 leaves ample margin
	initial begin
		#50000;
		num_errors++;
		wrap_up();
	end
	initial begin
		{presetn, psel, penable, pwrite, pkt, bse, raw} = 7'h00;
		{paddr, pwdata, cfg_a, cfg_b, st} = 76'h0;
		opm = OPM_STDBY;
		num_errors = 0;
		n_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_route(1'b1, OPM_RX, 8'h00, 8'h00, 0, 0, 1'b1);
		t_route(1'b1, OPM_TX, 8'h00, 8'h00, 1, 0, 1'b1);
		t_route(1'b1, OPM_RX, 8'h40, 8'h00, 2, 0, 1'b1);
		t_route(1'b1, OPM_STDBY, 8'hc0, 8'h00, 10, 0, 1'b1);
		t_route(1'b1, OPM_RX, 8'hc0, 8'h00, 11, 0, 1'b1);
		t_route(1'b1, OPM_RX, 8'h00, 8'h00, 3, 1, 1'b1);
		t_route(1'b1, OPM_RX, 8'h10, 8'h00, 4, 1, 1'b1);
		t_route(1'b1, OPM_RX, 8'h20, 8'h00, 5, 1, 1'b1);
		t_route(1'b1, OPM_RX, 8'h80, 8'h00, 0, 0, 1'b0);
		t_route(1'b0, OPM_RX, 8'h00, 8'h00, 6, 0, 1'b1);
		t_route(1'b0, OPM_RX, 8'h40, 8'h00, 9, 0, 1'b1);
		t_route(1'b0, OPM_RX, 8'h80, 8'h00, 7, 0, 1'b1);
		t_route(1'b0, OPM_TX, 8'h80, 8'h00, 8, 0, 1'b1);
		t_route(1'b0, OPM_RX, 8'h00, 8'h40, 12, 4, 1'b1);
		t_route(1'b0, OPM_SLEEP, 8'h00, 8'h00, 6, 0, 1'b0);
		t_route(1'b0, OPM_SLEEP, 8'h00, 8'h00, 14, 5, 1'b1);
		t_route(1'b1, OPM_RX, 8'h0c, 8'h00, 6, 2, 1'b1);
		t_route(1'b1, OPM_TX, 8'h01, 8'h00, 8, 3, 1'b1);
		t_route(1'b1, OPM_RX, 8'h00, 8'hc0, 9, 4, 1'b1);
		t_route(1'b1, OPM_RX, 8'h00, 8'h10, 12, 5, 1'b1);
		t_route(1'b0, OPM_STDBY, 8'h03, 8'h00, 10, 3, 1'b1);
		t_route(1'b0, OPM_STDBY, 8'h00, 8'hc0, 13, 4, 1'b1);
		t_route(1'b0, OPM_RX, 8'h00, 8'h80, 15, 4, 1'b1);
		t_cont_tx();
		t_cont_rx();
		wrap_up();
	end
endmodule : tb_top
